//--- wbm_defs.svh
// Purpose: offsets, field positions, reset values and codes of the watchdog/bus mode registers
// Assumes: 7-bit register addresses and 16-bit register words from the serial decoder
// Notes: definitions only

`ifndef WBM_DEFS_SVH
`define WBM_DEFS_SVH

// register addresses
`define WBM_ADDR_HW 7'h02
`define WBM_ADDR_WD 7'h03
`define WBM_ADDR_BUS 7'h04

// watchdog setup word fields
`define WBM_WD_CHECKSUM 15
`define WBM_WD_STOP_LO 6
`define WBM_WD_KIND 5
`define WBM_WD_BUS_WAKE 4
`define WBM_WD_PER_HI 2
`define WBM_WD_PER_LO 0
`define WBM_WD_WMASK 16'h8077

// bus transceiver mode word fields
`define WBM_BUS_FLASH 7
`define WBM_BUS_SLOW 6
`define WBM_BUS_TXGUARD 5
`define WBM_BUS_LIN_HI 4
`define WBM_BUS_LIN_LO 3
`define WBM_BUS_CAN2 2
`define WBM_BUS_CAN_HI 1
`define WBM_BUS_CAN_LO 0
`define WBM_BUS_WMASK 16'h00ff

// position of the high stop-disable bit in the hardware control word
`define WBM_HW_STOP_HI 2

// reset and forced values
`define WBM_WD_RST 16'h0014
`define WBM_WD_RESTART 16'h0004
`define WBM_BUS_RST 16'h0000
`define WBM_BUS_DEV_RST 16'h0019

// transceiver mode codes (low two bits of each field)
`define WBM_MODE_OFF 2'h0
`define WBM_MODE_WAKE 2'h1
`define WBM_MODE_RECV 2'h2
`define WBM_MODE_NORM 2'h3

// period length in milliseconds per code
`define WBM_PER_0 14'd10
`define WBM_PER_1 14'd20
`define WBM_PER_2 14'd50
`define WBM_PER_3 14'd100
`define WBM_PER_4 14'd200
`define WBM_PER_5 14'd500
`define WBM_PER_6 14'd1000
`define WBM_PER_7 14'd10000

`endif

//--- wbm_pkg.sv
// Purpose: types shared by the watchdog/bus mode register bank
// Assumes: nothing beyond the defs header
// Notes: numbers live in wbm_defs.svh

package wbm_pkg;

    // transceiver operating mode after decoding
    typedef enum logic [1:0] {
        WBM_XCVR_OFF = 2'h0,
        WBM_XCVR_WAKE = 2'h1,
        WBM_XCVR_RECV = 2'h2,
        WBM_XCVR_NORM = 2'h3
    } wbm_xcvr_mode_t;

    // watchdog flavour
    typedef enum logic {
        WBM_WD_TIMEOUT = 1'b0,
        WBM_WD_WINDOW = 1'b1
    } wbm_wd_kind_t;

    // whole state of the register bank
    typedef struct packed {
        logic init_done;
        logic [15:0] wd;
        logic [7:0] bus;
        logic stop_hi;
        logic [15:0] rdata;
        logic rhit;
        logic [13:0] period_ms;
        wbm_xcvr_mode_t can_mode;
        logic can_swk;
        wbm_xcvr_mode_t lin_mode;
        wbm_wd_kind_t wd_kind;
        logic wd_parity;
    } wbm_state_t;

endpackage : wbm_pkg

//--- wbm_decode.sv
// Purpose: turns the stored register words into mode and timing information
// Assumes: inputs are the next stored words from the caller's next-state logic
// Notes: purely combinational; the caller registers the results

`include "wbm_defs.svh"

module wbm_decode (
    input wire logic [15:0] wd_word_i,
    input wire logic [7:0] bus_word_i,
    output logic [13:0] period_ms_o,
    output wbm_pkg::wbm_xcvr_mode_t can_mode_o,
    output logic can_swk_o,
    output wbm_pkg::wbm_xcvr_mode_t lin_mode_o,
    output wbm_pkg::wbm_wd_kind_t wd_kind_o,
    output logic wd_parity_o
);

    // period code to milliseconds
    function automatic logic [13:0] wbm_period(input logic [2:0] code);
        logic [13:0] ms;
        ms = `WBM_PER_0;
        unique case (code)
            3'h0: ms = `WBM_PER_0;
            3'h1: ms = `WBM_PER_1;
            3'h2: ms = `WBM_PER_2;
            3'h3: ms = `WBM_PER_3;
            3'h4: ms = `WBM_PER_4;
            3'h5: ms = `WBM_PER_5;
            3'h6: ms = `WBM_PER_6;
            3'h7: ms = `WBM_PER_7;
        endcase
        return ms;
    endfunction

    always_comb begin
        period_ms_o = wbm_period(wd_word_i[`WBM_WD_PER_HI:`WBM_WD_PER_LO]);
    end

    assign wd_kind_o = wbm_pkg::wbm_wd_kind_t'(wd_word_i[`WBM_WD_KIND]);

    // checksum bit counts as plain 0 or 1 in the parity
    assign wd_parity_o = ^wd_word_i;

    // code 100 and 111 fall back to off; swk only with the top bit set
    always_comb begin
        can_mode_o = wbm_pkg::WBM_XCVR_OFF;
        can_swk_o = 1'b0;
        if (!bus_word_i[`WBM_BUS_CAN2]) begin
            can_mode_o = wbm_pkg::wbm_xcvr_mode_t'(bus_word_i[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO]);
        end else if (bus_word_i[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO] == `WBM_MODE_WAKE ||
                     bus_word_i[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO] == `WBM_MODE_RECV) begin
            can_mode_o = wbm_pkg::wbm_xcvr_mode_t'(bus_word_i[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO]);
            can_swk_o = 1'b1;
        end
    end

    assign lin_mode_o = wbm_pkg::wbm_xcvr_mode_t'(bus_word_i[`WBM_BUS_LIN_HI:`WBM_BUS_LIN_LO]);

endmodule // wbm_decode

//--- wbm_regs.sv
// Purpose: watchdog setup and bus transceiver mode registers with device side effects
// Assumes: the serial decoder hands over whole 16-bit words with one-cycle strobes
// Notes: mode-change events are one-cycle pulses from the device state machine
//        hardware events win over a software write in the same cycle
//        decoded outputs are registered together with the stored words

`include "wbm_defs.svh"

// What this block does
// - top watchdog bit feeds setting parity
// - watchdog bits fourteen to seven read zero
// - low stop-disable bit turns watchdog off
// - kind bit selects time-out or window
// - bus-wake start bit gates watchdog start
// - three-bit period code picks the period
// - reset loads watchdog word 0x0014
// - restart forces period code 100, sets wake-start per cause
// - flash bit switches off lin slope control
// - slow-edge bit picks low-slope lin
// - tx stuck guard follows its bit
// - two-bit lin mode decode
// - three-bit can mode decode with selective wake
// - top can mode bit only software-written or reset
// - sleep entry turns can normal into wake unless a system error is flagged
// - receive-only: wake on sleep, kept on stop
// - wake or off can mode left alone
// - fail-safe sets lin and can wake capable
// - reset clears bus word outside development mode; restart per cause
// - development mode resets can 001, lin 11
// - stop to normal clears high stop-disable
module wbm_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register access from the serial decoder
    input wire logic [6:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_hit_o,
    // device mode events
    input wire logic soft_reset_i,
    input wire logic restart_entry_i,
    input wire logic restart_bus_wake_i,
    input wire logic restart_lin_hi_i,
    input wire logic failsafe_entry_i,
    input wire logic sleep_entry_i,
    input wire logic stop_entry_i,
    input wire logic stop_to_normal_i,
    input wire logic system_error_flag_i,
    input wire logic sw_dev_mode_i,
    // watchdog controls
    output logic [13:0] wd_period_ms_o,
    output wbm_pkg::wbm_wd_kind_t wd_kind_o,
    output logic wd_stop_disable_lo_o,
    output logic wd_stop_disable_hi_o,
    output logic wd_off_in_stop_o,
    output logic wd_start_on_bus_wake_o,
    output logic wd_parity_o,
    // transceiver controls
    output wbm_pkg::wbm_xcvr_mode_t can_mode_o,
    output logic selective_wake_o,
    output wbm_pkg::wbm_xcvr_mode_t lin_mode_o,
    output logic lin_slope_on_o,
    output logic lin_slow_edge_select_o,
    output logic lin_tx_stuck_guard_o
);

    wbm_pkg::wbm_state_t st_q;
    wbm_pkg::wbm_state_t st_d;

    // decoder sees the next stored words so decoded outputs line up with them
    logic [13:0] dec_period;
    wbm_pkg::wbm_xcvr_mode_t dec_can;
    logic dec_swk;
    wbm_pkg::wbm_xcvr_mode_t dec_lin;
    wbm_pkg::wbm_wd_kind_t dec_kind;
    logic dec_parity;

    wbm_decode u_decode (
        .wd_word_i(st_d.wd),
        .bus_word_i(st_d.bus),
        .period_ms_o(dec_period),
        .can_mode_o(dec_can),
        .can_swk_o(dec_swk),
        .lin_mode_o(dec_lin),
        .wd_kind_o(dec_kind),
        .wd_parity_o(dec_parity)
    );

    // address decode, used for both write and read
    function automatic logic wbm_sel(input logic [6:0] addr, input logic [6:0] target);
        return addr == target;
    endfunction

    // power-on style value of the bus word, depending on development mode
    function automatic logic [7:0] wbm_bus_reset(input logic dev);
        logic [15:0] v;
        v = dev ? `WBM_BUS_DEV_RST : `WBM_BUS_RST;
        return v[7:0];
    endfunction

    // low-power entry on the can field; top bit never touched
    function automatic logic [1:0] wbm_can_lowpower(input logic [1:0] lo, input logic sleep,
                                                     input logic system_error_flag);
        logic [1:0] r;
        r = lo;
        unique case (lo)
            `WBM_MODE_NORM: begin
                // a pending system error keeps the transceiver as it is
                if (sleep && !system_error_flag) begin
                    r = `WBM_MODE_WAKE;
                end
            end
            `WBM_MODE_RECV: begin
                // stop keeps listening; sleep falls back to wake capable
                if (sleep) begin
                    r = `WBM_MODE_WAKE;
                end
            end
            `WBM_MODE_WAKE, `WBM_MODE_OFF: begin
                // already low-power modes, left alone
                r = lo;
            end
        endcase
        return r;
    endfunction

    // software view of a watchdog write; reserved positions never reach the flops
    function automatic logic [15:0] wbm_wd_write(input logic [15:0] data);
        return data & `WBM_WD_WMASK;
    endfunction

    // software view of a bus write; the upper byte is reserved and not stored,
    // which saves eight flops that could only ever hold zero
    function automatic logic [7:0] wbm_bus_write(input logic [15:0] data);
        return data[7:0];
    endfunction

    // restart value of the watchdog word; only the wake-start bit depends on the cause
    function automatic logic [15:0] wbm_wd_restart(input logic bus_wake);
        logic [15:0] v;
        // period code 100, everything else cleared
        v = `WBM_WD_RESTART;
        v[`WBM_WD_BUS_WAKE] = bus_wake;
        return v;
    endfunction

    // restart value of the bus word: slope options and can bit 2 survive, the top lin
    // mode bit follows the restart cause, the rest is cleared
    function automatic logic [7:0] wbm_bus_restart(input logic [7:0] bus, input logic lin_hi);
        logic [7:0] v;
        v = bus;
        v[`WBM_BUS_TXGUARD] = 1'b0;
        v[`WBM_BUS_LIN_HI] = lin_hi;
        v[`WBM_BUS_LIN_LO] = 1'b0;
        v[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO] = `WBM_MODE_OFF;
        return v;
    endfunction

    // fail-safe value of the bus word: both transceivers wake capable so that the
    // device can always be woken again; option bits and can bit 2 are kept
    function automatic logic [7:0] wbm_bus_failsafe(input logic [7:0] bus);
        logic [7:0] v;
        v = bus;
        v[`WBM_BUS_LIN_HI:`WBM_BUS_LIN_LO] = `WBM_MODE_WAKE;
        v[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO] = `WBM_MODE_WAKE;
        return v;
    endfunction

    // read multiplexer: bit 16 is the hit flag, bits 15:0 the data; unmapped reads
    // return zero without a hit so a wrong address cannot look like a cleared register
    function automatic logic [16:0] wbm_read(input logic [6:0] addr, input logic [15:0] wd,
                                             input logic [7:0] bus, input logic stop_hi);
        logic [16:0] r;
        r = 17'h00000;
        if (wbm_sel(addr, `WBM_ADDR_WD)) begin
            r = {1'b1, wd & `WBM_WD_WMASK};
        end else if (wbm_sel(addr, `WBM_ADDR_BUS)) begin
            r = {1'b1, 8'h00, bus};
        end else if (wbm_sel(addr, `WBM_ADDR_HW)) begin
            // only the high stop-disable bit lives here; the rest reads zero
            r[16] = 1'b1;
            r[`WBM_HW_STOP_HI] = stop_hi;
        end else begin
            // unmapped: no hit, zero data
            r = 17'h00000;
        end
        return r;
    endfunction

    // priority, lowest first: software write, stop-to-normal clear, low-power entry,
    // fail-safe, restart, reset; each later stage starts from what the earlier ones
    // left, except the low-power can field and can bit 2, which come from the stored
    // word, so a hardware event always wins over a write in the same cycle
    // reset stands last because it must leave its values whatever else happened
    // the words are settled before the decoded fields are taken, which keeps the
    // registered decode in step with the registered words at the same edge
    // limitation: two events in one cycle are merged, not queued

    // next-state logic: software write first, hardware events override it
    always_comb begin
        logic wr_wd;
        logic wr_bus;
        logic wr_hw;
        logic [15:0] wd_n;
        logic [7:0] bus_n;
        wr_wd = reg_wr_i && wbm_sel(reg_addr_i, `WBM_ADDR_WD);
        wr_bus = reg_wr_i && wbm_sel(reg_addr_i, `WBM_ADDR_BUS);
        wr_hw = reg_wr_i && wbm_sel(reg_addr_i, `WBM_ADDR_HW);
        st_d = st_q;
        wd_n = st_q.wd;
        bus_n = st_q.bus;

        if (wr_wd) begin
            wd_n = wbm_wd_write(reg_wdata_i);
        end
        // upper byte of the bus word is not stored at all
        if (wr_bus) begin
            bus_n = wbm_bus_write(reg_wdata_i);
        end
        // only the high stop-disable bit of the hardware word is kept here
        if (wr_hw) begin
            st_d.stop_hi = reg_wdata_i[`WBM_HW_STOP_HI];
        end

        // stop to normal clears high bit
        if (stop_to_normal_i) begin
            st_d.stop_hi = 1'b0;
        end

        if (sleep_entry_i || stop_entry_i) begin
            bus_n[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO] =
                wbm_can_lowpower(st_q.bus[`WBM_BUS_CAN_HI:`WBM_BUS_CAN_LO], sleep_entry_i,
                                 system_error_flag_i);
            // relies on software choosing receive-only beforehand
            bus_n[`WBM_BUS_CAN2] = st_q.bus[`WBM_BUS_CAN2];
        end

        if (failsafe_entry_i) begin
            bus_n = wbm_bus_failsafe(bus_n);
            // top can bit left to software
            bus_n[`WBM_BUS_CAN2] = st_q.bus[`WBM_BUS_CAN2];
        end

        if (restart_entry_i) begin
            wd_n = wbm_wd_restart(restart_bus_wake_i);
            // restart clears fixed bits, lin per cause
            bus_n = wbm_bus_restart(bus_n, restart_lin_hi_i);
            // top can bit stays as written
            bus_n[`WBM_BUS_CAN2] = st_q.bus[`WBM_BUS_CAN2];
        end

        // first cycle after power-on and every soft reset
        if (soft_reset_i || !st_q.init_done) begin
            wd_n = `WBM_WD_RST;
            bus_n = wbm_bus_reset(sw_dev_mode_i);
            st_d.stop_hi = 1'b0;
        end
        st_d.init_done = 1'b1;
        st_d.wd = wd_n;
        st_d.bus = bus_n;

        // read data captured on the read strobe; unmapped reads return zero
        if (reg_rd_i) begin
            {st_d.rhit, st_d.rdata} = wbm_read(reg_addr_i, st_q.wd, st_q.bus, st_q.stop_hi);
        end

        // decoded controls registered with the words
        st_d.period_ms = dec_period;
        st_d.can_mode = dec_can;
        st_d.can_swk = dec_swk;
        st_d.lin_mode = dec_lin;
        st_d.wd_kind = dec_kind;
        st_d.wd_parity = dec_parity;
    end

    // state register; async reset takes constants only, so the development-mode strap
    // cannot be applied here: the init cycle after release loads the words instead,
    // and any write or mode event in that first cycle is overwritten; a read is still answered
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q.init_done <= 1'b0;
            st_q.wd <= `WBM_WD_RST;
            st_q.bus <= 8'h00;
            st_q.stop_hi <= 1'b0;
            st_q.rdata <= 16'h0000;
            st_q.rhit <= 1'b0;
            st_q.period_ms <= `WBM_PER_4;
            st_q.can_mode <= wbm_pkg::WBM_XCVR_OFF;
            st_q.can_swk <= 1'b0;
            st_q.lin_mode <= wbm_pkg::WBM_XCVR_OFF;
            st_q.wd_kind <= wbm_pkg::WBM_WD_TIMEOUT;
            st_q.wd_parity <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // read port; data and hit stand until the next read strobe
    // so the serial side may pick them up late
    assign reg_rdata_o = st_q.rdata;
    assign reg_hit_o = st_q.rhit;

    assign wd_period_ms_o = st_q.period_ms;
    assign wd_kind_o = st_q.wd_kind;
    // parity over the whole stored word
    assign wd_parity_o = st_q.wd_parity;
    assign wd_start_on_bus_wake_o = st_q.wd[`WBM_WD_BUS_WAKE];

    // either stop-disable bit switches the watchdog off in stop
    assign wd_stop_disable_lo_o = st_q.wd[`WBM_WD_STOP_LO];
    assign wd_stop_disable_hi_o = st_q.stop_hi;
    assign wd_off_in_stop_o = st_q.wd[`WBM_WD_STOP_LO] | st_q.stop_hi;

    assign can_mode_o = st_q.can_mode;
    assign selective_wake_o = st_q.can_swk;
    assign lin_mode_o = st_q.lin_mode;
    assign lin_slope_on_o = ~st_q.bus[`WBM_BUS_FLASH];
    assign lin_slow_edge_select_o = st_q.bus[`WBM_BUS_SLOW];
    assign lin_tx_stuck_guard_o = st_q.bus[`WBM_BUS_TXGUARD];

endmodule // wbm_regs

//--- wbm_regs_properties.sv
// Purpose: port-level properties of the watchdog/bus mode registers
// Assumes: one clock domain, async active-low reset
// Notes: hardware events override same-cycle writes, so writes are checked alone
module wbm_regs_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_hit_o,
    input wire logic soft_reset_i,
    input wire logic restart_entry_i,
    input wire logic restart_bus_wake_i,
    input wire logic failsafe_entry_i,
    input wire logic sleep_entry_i,
    input wire logic stop_entry_i,
    input wire logic stop_to_normal_i,
    input wire logic system_error_flag_i,
    input wire logic [13:0] wd_period_ms_o,
    input wire wbm_pkg::wbm_wd_kind_t wd_kind_o,
    input wire logic wd_stop_disable_hi_o,
    input wire logic wd_off_in_stop_o,
    input wire logic wd_start_on_bus_wake_o,
    input wire wbm_pkg::wbm_xcvr_mode_t can_mode_o,
    input wire wbm_pkg::wbm_xcvr_mode_t lin_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // reset, restart and fail-safe events, which may override a write
    logic hw;
    assign hw = soft_reset_i | restart_entry_i | failsafe_entry_i;
    a_mapped_read_hit: assert property (
        reg_rd_i && reg_addr_i inside {7'h02, 7'h03, 7'h04} |=> reg_hit_o)
        else $error("mapped read without hit");
    a_unmapped_read_zero: assert property (
        reg_rd_i && !(reg_addr_i inside {7'h02, 7'h03, 7'h04})
        |=> reg_rdata_o == 16'h0000 && !reg_hit_o) else $error("unmapped read answered");
    a_wd_reserved_zero: assert property (
        reg_rd_i && reg_addr_i == 7'h03 |=> reg_rdata_o[14:7] == 8'h00 && !reg_rdata_o[3])
        else $error("watchdog reserved bits not zero");
    a_bus_upper_zero: assert property (
        reg_rd_i && reg_addr_i == 7'h04 |=> reg_rdata_o[15:8] == 8'h00)
        else $error("bus word upper byte not zero");
    a_period_longest: assert property (
        reg_wr_i && reg_addr_i == 7'h03 && !hw && $past(reset_n_i)
        && reg_wdata_i[2:0] == 3'h7 |=> wd_period_ms_o == 14'h2710)
        else $error("period code 7 not 10000 ms");
    a_stop_off_write: assert property (
        reg_wr_i && reg_addr_i == 7'h03 && !hw && $past(reset_n_i)
        |=> wd_off_in_stop_o == ($past(reg_wdata_i[6]) | wd_stop_disable_hi_o))
        else $error("stop-disable does not follow write");
    a_restart_wd_word: assert property (
        restart_entry_i && !soft_reset_i |=> wd_period_ms_o == 14'h00c8
        && wd_kind_o == wbm_pkg::WBM_WD_TIMEOUT
        && wd_start_on_bus_wake_o == $past(restart_bus_wake_i)) else $error("restart wd word");
    a_sleep_norm_wake: assert property (
        sleep_entry_i && !system_error_flag_i && !hw && can_mode_o == wbm_pkg::WBM_XCVR_NORM
        |=> can_mode_o == wbm_pkg::WBM_XCVR_WAKE) else $error("sleep kept can normal");
    a_stop_keeps_recv: assert property (
        stop_entry_i && !sleep_entry_i && !hw && !reg_wr_i
        && can_mode_o == wbm_pkg::WBM_XCVR_RECV |=> $stable(can_mode_o))
        else $error("stop changed receive-only");
    a_failsafe_wake: assert property (
        failsafe_entry_i && !restart_entry_i && !soft_reset_i
        |=> lin_mode_o == wbm_pkg::WBM_XCVR_WAKE && can_mode_o == wbm_pkg::WBM_XCVR_WAKE)
        else $error("fail-safe modes not wake");
    a_stop_hi_clear: assert property (
        stop_to_normal_i |=> !wd_stop_disable_hi_o) else $error("high stop-disable kept");
endmodule // wbm_regs_properties

bind wbm_regs wbm_regs_properties u_wbm_regs_properties (.clk_i, .reset_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_hit_o, .soft_reset_i,
    .restart_entry_i, .restart_bus_wake_i, .failsafe_entry_i, .sleep_entry_i, .stop_entry_i,
    .stop_to_normal_i, .system_error_flag_i, .wd_period_ms_o, .wd_kind_o,
    .wd_stop_disable_hi_o, .wd_off_in_stop_o, .wd_start_on_bus_wake_o, .can_mode_o,
    .lin_mode_o);

//--- wbm_regs_tb_top.sv
// Purpose: self-checking bench for the watchdog/bus mode registers
// Assumes: inputs change on the falling clock edge
// Notes: register rows first, then decode and option cases, then mode-event rows, then hand-written cases
module wbm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [6:0] a; // address, or event mask in the event rows
        logic [15:0] w;
        logic [15:0] r;
    } wbm_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [5:0] events = 6'h00; // soft, restart, fail-safe, sleep, stop, stop-to-normal
    logic system_error_flag = 1'b0;
    logic bus_wake = 1'b0;
    logic lin_hi = 1'b1;
    logic dev = 1'b0;
    logic [15:0] rdata;
    logic hit, lo, hi, off_stop, wake_start, parity, selective_wake, slope, slow, guard;
    logic [13:0] period;
    wbm_pkg::wbm_wd_kind_t kind;
    wbm_pkg::wbm_xcvr_mode_t can_m, lin_m;
    int failures = 0;
    int checked = 0;
    logic [13:0] per [8] = '{14'h00a, 14'h014, 14'h032, 14'h064, 14'h0c8, 14'h1f4,
        14'h3e8, 14'h2710};
    wbm_row_t rows [5] = '{'{7'h03, 16'hffff, 16'h8077}, '{7'h04, 16'hffff, 16'h00ff},
        '{7'h02, 16'hffff, 16'h0004}, '{7'h05, 16'hffff, 16'h0000},
        '{7'h03, 16'h8063, 16'h8063}};
    // low-power entries keep bit 2 of the can field; restart keeps bits 7, 6 and 2
    wbm_row_t fx [10] = '{'{7'h04, 16'h3, 16'h1}, '{7'h02, 16'h2, 16'h2},
        '{7'h04, 16'h2, 16'h1}, '{7'h04, 16'h7, 16'h5}, '{7'h02, 16'h6, 16'h6},
        '{7'h04, 16'h1, 16'h1}, '{7'h04, 16'h0, 16'h0}, '{7'h08, 16'he6, 16'hed},
        '{7'h08, 16'h4, 16'hd}, '{7'h10, 16'hff, 16'hd4}};

    wbm_regs u_wbm_regs (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .reg_hit_o(hit), .soft_reset_i(events[5]), .restart_entry_i(events[4]),
        .restart_bus_wake_i(bus_wake), .restart_lin_hi_i(lin_hi),
        .failsafe_entry_i(events[3]), .sleep_entry_i(events[2]), .stop_entry_i(events[1]),
        .stop_to_normal_i(events[0]), .system_error_flag_i(system_error_flag), .sw_dev_mode_i(dev),
        .wd_period_ms_o(period), .wd_kind_o(kind), .wd_stop_disable_lo_o(lo),
        .wd_stop_disable_hi_o(hi), .wd_off_in_stop_o(off_stop),
        .wd_start_on_bus_wake_o(wake_start), .wd_parity_o(parity), .can_mode_o(can_m),
        .selective_wake_o(selective_wake), .lin_mode_o(lin_m), .lin_slope_on_o(slope),
        .lin_slow_edge_select_o(slow), .lin_tx_stuck_guard_o(guard));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    // one-cycle write strobe; decoded outputs are settled on return
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk_i);
        wr_s = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(negedge clk_i);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk_i);
        rd_s = 1'b0;
        chk("rdata", e, rdata);
    endtask

    task automatic ev(input logic [5:0] m);
        @(negedge clk_i);
        events = m;
        @(negedge clk_i);
        events = 6'h00;
    endtask

    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far beyond the fewer than two hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        final_report();
    end

    initial begin
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("period", 16'h00c8, 16'(period));
        rd(7'h03, 16'h0014);
        rd(7'h04, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
            chk("hit", 16'(rows[i].a inside {7'h02, 7'h03, 7'h04}), 16'(hit));
        end
        for (int i = 0; i < 8; i++) begin
            wr(7'h03, 16'(i));
            chk("period", 16'(per[i]), 16'(period));
            wr(7'h04, 16'(i + (i % 4) * 8));
            chk("can", 16'((i == 4 || i == 7) ? 0 : i % 4), 16'(can_m));
            chk("swk", 16'(i == 5 || i == 6), 16'(selective_wake));
            chk("lin", 16'(i % 4), 16'(lin_m));
        end
        wr(7'h03, 16'h8060);
        chk("kind", 16'h0001, 16'(kind));
        chk("stop", 16'h0003, 16'({lo, off_stop}));
        chk("parity", 16'h0001, 16'(parity));
        wr(7'h03, 16'h8010);
        chk("parity", 16'h0000, 16'(parity));
        chk("wake", 16'h0002, 16'({wake_start, kind}));
        wr(7'h04, 16'h00a0);
        chk("lin opt", 16'h0001, 16'({slope, slow, guard}));
        wr(7'h04, 16'h0040);
        chk("lin opt", 16'h0006, 16'({slope, slow, guard}));
        foreach (fx[i]) begin
            wr(7'h04, fx[i].w);
            ev(fx[i].a[5:0]); // receive-only set before stop
            rd(7'h04, fx[i].r);
        end
        system_error_flag = 1'b1;
        wr(7'h04, 16'h0003);
        ev(6'h04);
        rd(7'h04, 16'h0003);
        system_error_flag = 1'b0;
        wr(7'h03, 16'h8063);
        ev(6'h10);
        rd(7'h03, 16'h0004);
        rd(7'h04, 16'h0010);
        bus_wake = 1'b1;
        lin_hi = 1'b0;
        ev(6'h10);
        rd(7'h03, 16'h0014);
        rd(7'h04, 16'h0000);
        dev = 1'b1;
        ev(6'h20);
        rd(7'h04, 16'h0019);
        dev = 1'b0;
        wr(7'h03, 16'h8063);
        ev(6'h20);
        rd(7'h03, 16'h0014);
        rd(7'h04, 16'h0000);
        wr(7'h02, 16'h0004);
        chk("stop hi", 16'h0001, 16'(hi));
        ev(6'h01);
        chk("stop hi", 16'h0000, 16'(hi));
        chk("stop off", 16'h0000, 16'(off_stop));
        // second reset in mid-run
        wr(7'h04, 16'h00ff);
        wr(7'h03, 16'h8067);
        @(negedge clk_i);
        reset_n_i = 1'b0;
        @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("period", 16'h00c8, 16'(period));
        rd(7'h04, 16'h0000);
        final_report();
    end
endmodule // wbm_regs_tb_top
